// *** bench/tb.sv ***
/*
 self-checking bench for the timer output block.
 assumes the panel model makes key edits; the instance gets short tick counts so timed expiry fits the run.
*/
`timescale 1ns/100ps
module tb;
	import toc_pkg::*;
	typedef struct {int id; logic [31:0] exp;} toc_note_t;
	logic i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_powerup = 1'b0, i_powerup_reset_en = 1'b1;
	logic i_timer_reset = 1'b0, i_reset_to_preset = 1'b0, i_output_reset = 1'b0;
	logic i_output_resolution_sel = 1'b0, i_prog_disabled = 1'b1, i_track_en = 1'b0;
	logic [31:0] i_saved_timer = 32'h0000_0000, i_timer_value = 32'h0000_0000;
	logic [1:0] i_output_polarity_invert = 2'h0, i_indicator_polarity_invert = 2'h0, i_saved_output = 2'h0;
	logic [3:0] i_output_powerup_state = 4'h0, i_output_operation_mode = 4'h0;
	logic [3:0] i_preset_access_level = 4'h0, i_time_access_level = 4'h0;
	logic i_preset_wr1, i_preset_wr2, o_timer_load;
	logic [31:0] i_preset_wdata, o_timer_load_val, o_preset1, o_preset2;
	logic [1:0] i_dur_wr, o_output, o_indicator, relay, lamp;
	logic [15:0] i_dur_wdata, o_dur1, o_dur2;
	logic [3:0] o_main_show, o_main_edit, o_prot_show;
	toc_note_t notes[$];
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	string nm[11] = '{"load", "load_val", "preset1", "preset2", "dur1", "dur2", "relay", "lamp", "show", "edit", "prot"};
	localparam int TB_FINE = 4;
	localparam int TB_COARSE = 12;
	toc_timer_output #(.DUAL(1), .TICK_CYC_FINE(TB_FINE), .TICK_CYC_COARSE(TB_COARSE)) dut_u (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_powerup(i_powerup),
		.i_powerup_reset_en(i_powerup_reset_en),
		.i_saved_timer(i_saved_timer),
		.i_timer_value(i_timer_value),
		.i_timer_reset(i_timer_reset),
		.i_reset_to_preset(i_reset_to_preset),
		.i_output_reset(i_output_reset),
		.i_output_resolution_sel(i_output_resolution_sel),
		.i_output_polarity_invert(i_output_polarity_invert),
		.i_indicator_polarity_invert(i_indicator_polarity_invert),
		.i_output_powerup_state(i_output_powerup_state),
		.i_output_operation_mode(i_output_operation_mode),
		.i_saved_output(i_saved_output),
		.i_preset_access_level(i_preset_access_level),
		.i_time_access_level(i_time_access_level),
		.i_prog_disabled(i_prog_disabled),
		.i_track_en(i_track_en),
		.i_preset_wr1(i_preset_wr1),
		.i_preset_wr2(i_preset_wr2),
		.i_preset_wdata(i_preset_wdata),
		.i_dur_wr(i_dur_wr),
		.i_dur_wdata(i_dur_wdata),
		.o_timer_load(o_timer_load),
		.o_timer_load_val(o_timer_load_val),
		.o_preset1(o_preset1),
		.o_preset2(o_preset2),
		.o_dur1(o_dur1),
		.o_dur2(o_dur2),
		.o_output(o_output),
		.o_indicator(o_indicator),
		.o_main_show(o_main_show),
		.o_main_edit(o_main_edit),
		.o_prot_show(o_prot_show));
	toc_panel_model pnl_u (.i_clk_sys(i_clk_sys), .i_output(o_output), .i_indicator(o_indicator),
		.o_preset_wr1(i_preset_wr1), .o_preset_wr2(i_preset_wr2), .o_preset_wdata(i_preset_wdata),
		.o_dur_wr(i_dur_wr), .o_dur_wdata(i_dur_wdata), .o_relay(relay), .o_lamp(lamp));
	always #2.5 i_clk_sys = ~i_clk_sys;
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] seen(int id);
		case (id)
			0: return 32'(o_timer_load);
			1: return o_timer_load_val;
			2: return o_preset1;
			3: return o_preset2;
			4: return 32'(o_dur1);
			5: return 32'(o_dur2);
			6: return 32'(relay);
			7: return 32'(lamp);
			8: return 32'(o_main_show);
			9: return 32'(o_main_edit);
			default: return 32'(o_prot_show);
		endcase
	endfunction : seen
	task automatic chk(input int id, input logic [31:0] e);
		notes.push_back('{id, e});
	endtask : chk
	task automatic end_sim();
		if (n_fail == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim
	// outputs are settled by the falling edge, so notes are taken there
	always @(negedge i_clk_sys)
	begin
		while (notes.size() > 0)
		begin
			toc_note_t n;
			n = notes.pop_front();
			num_checks++;
			if (seen(n.id) !== n.exp)
			begin
				n_fail++;
				$display("FAIL %s exp %h got %h", nm[n.id], n.exp, seen(n.id));
			end
		end
	end
	always @(posedge i_clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////
	initial
	begin
		logic [31:0] r, p;
		void'($urandom(32'h54c9_1d02));
		repeat (5) @(posedge i_clk_sys);
		i_sys_rst <= 1'b0;
		for (int s = 0; s < 3; s++)
		begin
			r = $urandom;
			@(posedge i_clk_sys);
			i_saved_timer <= r;
			i_powerup_reset_en <= s[0];
			i_output_powerup_state <= {2{s[1:0]}};
			i_saved_output <= 2'h3;
			i_powerup <= 1'b1;
			@(posedge i_clk_sys);
			i_powerup <= 1'b0;
			chk(0, 32'h0000_0001);
			chk(1, s[0] ? 32'h0000_0000 : r);
			chk(6, (s == 0) ? 32'h0000_0000 : 32'h0000_0003);
		end
		r = $urandom_range(32'h0000_FFFF, 32'h0000_1000);
		p = r;
		pnl_u.edit_preset(2, r);
		pnl_u.edit_preset(1, r - 32'h0000_0100);
		chk(3, r);
		i_track_en <= 1'b1;
		pnl_u.edit_preset(2, r + 32'h0000_0050);
		chk(2, r - 32'h0000_00B0);
		pnl_u.edit_preset(1, r - 32'h0000_0010);
		pnl_u.edit_preset(2, r);
		chk(2, r - 32'h0000_0060);
		i_track_en <= 1'b0;
		for (int k = 0; k < 4; k++)
		begin
			@(posedge i_clk_sys);
			i_timer_reset <= 1'b1;
			i_timer_value <= 32'h0000_0000;
			i_output_polarity_invert <= k[1:0];
			i_indicator_polarity_invert <= ~k[1:0];
			@(posedge i_clk_sys);
			i_timer_reset <= 1'b0;
			i_timer_value <= r - 32'h0000_0060;
			chk(6, 32'(k[1:0]));
			@(posedge i_clk_sys);
			chk(6, 32'(2'h1 ^ k[1:0]));
			chk(7, 32'h0000_0002);
		end
		for (int a = 0; a < 4; a++)
		begin
			@(posedge i_clk_sys);
			i_preset_access_level <= {2{a[1:0]}};
			i_time_access_level <= {2{a[1:0]}};
			@(posedge i_clk_sys);
			chk(8, (a >= 2) ? 32'h0000_000F : 32'h0000_0000);
			chk(9, (a == 3) ? 32'h0000_000F : 32'h0000_0000);
			chk(10, (a == 1 || a == 2) ? 32'h0000_000F : 32'h0000_0000);
		end
		pnl_u.edit_dur(1, 16'h0000);
		chk(4, 32'h0000_0001);
		pnl_u.edit_dur(2, 16'hFFFF);
		chk(5, 32'h0000_270F);
		r = $urandom_range(9999, 1);
		pnl_u.edit_dur(1, r[15:0]);
		chk(4, r);
		// timed output 1 on fine ticks: on for at least 2 and at most 3 tick periods
		pnl_u.edit_dur(1, 16'h0003);
		@(posedge i_clk_sys);
		i_output_polarity_invert <= 2'h0;
		i_output_operation_mode <= 4'h5;
		i_output_reset <= 1'b1;
		i_timer_value <= 32'h0000_0000;
		@(posedge i_clk_sys);
		i_output_reset <= 1'b0;
		i_timer_value <= p - 32'h0000_0060;
		chk(6, 32'h0000_0000);
		@(posedge i_clk_sys);
		chk(6, 32'h0000_0001);
		repeat (2 * TB_FINE) @(posedge i_clk_sys);
		chk(6, 32'h0000_0001);
		repeat (TB_FINE) @(posedge i_clk_sys);
		chk(6, 32'h0000_0000);
		// timed output 2 on coarse ticks
		i_output_resolution_sel <= 1'b1;
		pnl_u.edit_dur(2, 16'h0002);
		i_timer_value <= p;
		@(posedge i_clk_sys);
		chk(6, 32'h0000_0002);
		repeat (TB_COARSE) @(posedge i_clk_sys);
		chk(6, 32'h0000_0002);
		repeat (TB_COARSE) @(posedge i_clk_sys);
		chk(6, 32'h0000_0000);
		// output 1 off at output 2, then compare against zero after a reset
		i_output_operation_mode <= 4'h2;
		i_timer_value <= p - 32'h0000_0060;
		@(posedge i_clk_sys);
		chk(6, 32'h0000_0001);
		i_timer_value <= p;
		@(posedge i_clk_sys);
		chk(6, 32'h0000_0002);
		i_reset_to_preset <= 1'b1;
		i_timer_reset <= 1'b1;
		i_timer_value <= 32'h0000_0000;
		@(posedge i_clk_sys);
		i_timer_reset <= 1'b0;
		chk(6, 32'h0000_0000);
		@(posedge i_clk_sys);
		chk(6, 32'h0000_0003);
		chk(7, 32'h0000_0003);
		repeat (2) @(posedge i_clk_sys);
		end_sim();
	end
endmodule : tb

// *** bench/toc_panel_model.sv ***
/*
 front panel keypad, relay contacts and annunciator lamps facing the timer output block.
 assumes the bench calls the edit tasks from its clocked sequence.
*/
`timescale 1ns/100ps
module toc_panel_model
	import toc_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic [toc_pkg::NOUT-1:0] i_output,
	input wire logic [toc_pkg::NOUT-1:0] i_indicator,
	output logic o_preset_wr1,
	output logic o_preset_wr2,
	output logic [toc_pkg::VAL_W-1:0] o_preset_wdata,
	output logic [toc_pkg::NOUT-1:0] o_dur_wr,
	output logic [toc_pkg::DUR_W-1:0] o_dur_wdata,
	output logic [toc_pkg::NOUT-1:0] o_relay,
	output logic [toc_pkg::NOUT-1:0] o_lamp
);
	initial
	begin
		o_preset_wr1 = 1'b0;
		o_preset_wr2 = 1'b0;
		o_preset_wdata = 32'h0000_0000;
		o_dur_wr = 2'h0;
		o_dur_wdata = 16'h0000;
	end
	// contacts follow the drive lines, no bounce modelled
	assign o_relay = i_output;
	assign o_lamp = i_indicator;
	////////////////////////////////////////////////////////////
	// one key entry is a one-cycle strobe; data is scrambled after so a stale value never looks valid
	task automatic edit_preset(input int idx, input logic [VAL_W-1:0] val);
		@(posedge i_clk_sys);
		o_preset_wr1 <= (idx == 1);
		o_preset_wr2 <= (idx == 2);
		o_preset_wdata <= val;
		@(posedge i_clk_sys);
		o_preset_wr1 <= 1'b0;
		o_preset_wr2 <= 1'b0;
		o_preset_wdata <= ~val;
	endtask : edit_preset
	task automatic edit_dur(input int idx, input logic [DUR_W-1:0] val);
		@(posedge i_clk_sys);
		o_dur_wr <= 2'(idx);
		o_dur_wdata <= val;
		@(posedge i_clk_sys);
		o_dur_wr <= 2'h0;
		o_dur_wdata <= ~val;
	endtask : edit_dur
endmodule : toc_panel_model

// *** hdl/toc_pkg.sv ***
/*
 constants and types shared by the timer output configuration block.
 assumes a single 200 MHz system clock.
*/
package toc_pkg;
	localparam int CLK_HZ = 200_000_000;
	localparam int TICK_FINE_MS10 = 1;
	localparam int TICK_COARSE_MS10 = 10;
	localparam longint CYC_FINE = longint'(CLK_HZ) * TICK_FINE_MS10 / 100;
	localparam longint CYC_COARSE = longint'(CLK_HZ) * TICK_COARSE_MS10 / 100;
	localparam logic [15:0] DUR_MIN = 16'h0001;
	localparam logic [15:0] DUR_MAX = 16'h270F;
	localparam int VAL_W = 32;
	localparam int DUR_W = 16;
	localparam int NOUT = 2;
	localparam logic [VAL_W-1:0] TIMER_RST_VAL = 32'h0000_0000;
	typedef enum logic [1:0] {
		TOC_ACC_LOCKED = 2'b00,
		TOC_ACC_PROT = 2'b01,
		TOC_ACC_VIEW = 2'b10,
		TOC_ACC_FULL = 2'b11
	} toc_access_t;
	typedef enum logic [1:0] {
		TOC_PU_OFF = 2'b00,
		TOC_PU_ON = 2'b01,
		TOC_PU_PREV = 2'b10
	} toc_powerup_t;
	typedef enum logic [1:0] {
		TOC_OP_LATCHED = 2'b00,
		TOC_OP_TIMED = 2'b01,
		TOC_OP_OFF_AT_O2 = 2'b10
	} toc_opmode_t;
endpackage : toc_pkg

// *** hdl/toc_timer_output.sv ***
/*
 preset compare, timed outputs, polarity, power-up state, preset tracking and access visibility.
 assumes the operating-mode sequencer supplies timer value, reset and mode bits; one clock.
*/
`timescale 1ns/100ps
module toc_timer_output
	import toc_pkg::*;
#(
	parameter int DUAL = 1,
	parameter longint TICK_CYC_FINE = toc_pkg::CYC_FINE,
	parameter longint TICK_CYC_COARSE = toc_pkg::CYC_COARSE
)(
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_powerup,
	input wire logic i_powerup_reset_en,
	input wire logic [toc_pkg::VAL_W-1:0] i_saved_timer,
	input wire logic [toc_pkg::VAL_W-1:0] i_timer_value,
	input wire logic i_timer_reset,
	input wire logic i_reset_to_preset,
	input wire logic i_output_reset,
	input wire logic i_output_resolution_sel,
	input wire logic [toc_pkg::NOUT-1:0] i_output_polarity_invert,
	input wire logic [toc_pkg::NOUT-1:0] i_indicator_polarity_invert,
	input wire logic [3:0] i_output_powerup_state,
	input wire logic [3:0] i_output_operation_mode,
	input wire logic [toc_pkg::NOUT-1:0] i_saved_output,
	input wire logic [3:0] i_preset_access_level,
	input wire logic [3:0] i_time_access_level,
	input wire logic i_prog_disabled,
	input wire logic i_track_en,
	input wire logic i_preset_wr1,
	input wire logic i_preset_wr2,
	input wire logic [toc_pkg::VAL_W-1:0] i_preset_wdata,
	input wire logic [toc_pkg::NOUT-1:0] i_dur_wr,
	input wire logic [toc_pkg::DUR_W-1:0] i_dur_wdata,
	output logic o_timer_load,
	output logic [toc_pkg::VAL_W-1:0] o_timer_load_val,
	output logic [toc_pkg::VAL_W-1:0] o_preset1,
	output logic [toc_pkg::VAL_W-1:0] o_preset2,
	output logic [toc_pkg::DUR_W-1:0] o_dur1,
	output logic [toc_pkg::DUR_W-1:0] o_dur2,
	output logic [toc_pkg::NOUT-1:0] o_output,
	output logic [toc_pkg::NOUT-1:0] o_indicator,
	output logic [3:0] o_main_show,
	output logic [3:0] o_main_edit,
	output logic [3:0] o_prot_show
);
	import toc_pkg::*;

	////////////////////////////////////////////////////////////////
	// timer restore or clear at power-up
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			o_timer_load <= 1'b0;
			o_timer_load_val <= TIMER_RST_VAL;
		end
		else
		begin
			o_timer_load <= i_powerup;
			if (i_powerup)
				o_timer_load_val <= i_powerup_reset_en ? TIMER_RST_VAL : i_saved_timer;
		end
	end

	////////////////////////////////////////////////////////////////
	// presets with tracking offset
	logic [VAL_W-1:0] offset;
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			o_preset1 <= '0;
			o_preset2 <= '0;
			offset <= '0;
		end
		else if (i_preset_wr1)
		begin
			o_preset1 <= i_preset_wdata;
			offset <= o_preset2 - i_preset_wdata;
		end
		else if (i_preset_wr2 && DUAL != 0)
		begin
			o_preset2 <= i_preset_wdata;
			if (i_track_en)
				o_preset1 <= i_preset_wdata - offset;
			else
				offset <= i_preset_wdata - o_preset1;
		end
	end

	////////////////////////////////////////////////////////////////
	// duration values, clamped to the tick range
	function automatic logic [DUR_W-1:0] clamp_dur(input logic [DUR_W-1:0] v);
		clamp_dur = (v < DUR_MIN) ? DUR_MIN : ((v > DUR_MAX) ? DUR_MAX : v);
	endfunction : clamp_dur

	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			o_dur1 <= DUR_MIN;
			o_dur2 <= DUR_MIN;
		end
		else
		begin
			if (i_dur_wr[0])
				o_dur1 <= clamp_dur(i_dur_wdata);
			if (i_dur_wr[1])
				o_dur2 <= clamp_dur(i_dur_wdata);
		end
	end

	////////////////////////////////////////////////////////////////
	// resolution tick divider, shared by all outputs
	// sized for the slower tick; a fine tick longer than the coarse one would be cut short
	localparam int DIV_W = $clog2(TICK_CYC_COARSE + 1);
	logic [DIV_W-1:0] div_cnt;
	logic tick;
	logic [DIV_W-1:0] div_top;
	assign div_top = i_output_resolution_sel ? DIV_W'(TICK_CYC_COARSE - 1) : DIV_W'(TICK_CYC_FINE - 1);
	assign tick = (div_cnt >= div_top);
	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
			div_cnt <= '0;
		else if (tick)
			div_cnt <= '0;
		else
			div_cnt <= div_cnt + 1'b1;
	end

	////////////////////////////////////////////////////////////////
	// per-output logical state and duration counter
	logic [NOUT-1:0] act;
	logic [NOUT-1:0] hit;
	logic [NOUT-1:0] hit_d;
	logic [DUR_W-1:0] dcnt [NOUT];
	logic [DUR_W-1:0] dur [NOUT];
	logic [VAL_W-1:0] pre [NOUT];
	assign dur[0] = o_dur1;
	assign dur[1] = o_dur2;
	assign pre[0] = o_preset1;
	assign pre[1] = o_preset2;

	genvar g;
	generate
		for (g = 0; g < NOUT; g++)
		begin : g_out
			logic [1:0] pu;
			logic [1:0] mode;
			logic en;
			assign pu = i_output_powerup_state[2*g+:2];
			assign mode = i_output_operation_mode[2*g+:2];
			assign en = (g == 0) || (DUAL != 0);
			// preset reached, or zero in reset-to-preset modes
			assign hit[g] = en && (i_reset_to_preset ? (i_timer_value == '0) : (i_timer_value == pre[g]));

			always_ff @(posedge i_clk_sys)
			begin
				if (i_sys_rst)
				begin
					act[g] <= 1'b0;
					// an equality already standing at reset or power-up is not a new preset event
					hit_d[g] <= 1'b1;
					dcnt[g] <= '0;
				end
				else if (i_powerup)
				begin
					hit_d[g] <= hit[g];
					dcnt[g] <= '0;
					unique case (pu)
						TOC_PU_ON: act[g] <= en;
						TOC_PU_PREV: act[g] <= en && (mode == TOC_OP_LATCHED) && i_saved_output[g];
						default: act[g] <= 1'b0;
					endcase
				end
				else if (i_timer_reset || i_output_reset)
				begin
					act[g] <= 1'b0;
					hit_d[g] <= 1'b0;
					dcnt[g] <= '0;
				end
				else
				begin
					hit_d[g] <= hit[g];
					if (hit[g] && !hit_d[g])
					begin
						act[g] <= 1'b1;
						dcnt[g] <= '0;
					end
					else if (g == 0 && DUAL != 0 && mode == TOC_OP_OFF_AT_O2 && hit[NOUT-1])
						act[g] <= 1'b0;
					else if (act[g] && mode == TOC_OP_TIMED && tick)
					begin
						if (dcnt[g] + 1'b1 >= dur[g])
						begin
							act[g] <= 1'b0;
							dcnt[g] <= '0;
						end
						else
							dcnt[g] <= dcnt[g] + 1'b1;
					end
				end
			end

			// polarity and indicator; reversal is per output
			assign o_output[g] = act[g] ^ (en & i_output_polarity_invert[g]);
			assign o_indicator[g] = o_output[g] ^ i_indicator_polarity_invert[g];

			// visibility for the preset (index g) and output time (index 2+g)
			toc_access_t pa;
			toc_access_t ta;
			assign pa = toc_access_t'(i_preset_access_level[2*g+:2]);
			assign ta = toc_access_t'(i_time_access_level[2*g+:2]);
			assign o_main_show[g] = en && (pa == TOC_ACC_VIEW || pa == TOC_ACC_FULL);
			assign o_main_edit[g] = en && (pa == TOC_ACC_FULL || (pa == TOC_ACC_VIEW && !i_prog_disabled));
			assign o_prot_show[g] = en && (pa == TOC_ACC_PROT || pa == TOC_ACC_VIEW);
			assign o_main_show[2+g] = en && (ta == TOC_ACC_VIEW || ta == TOC_ACC_FULL);
			assign o_main_edit[2+g] = en && (ta == TOC_ACC_FULL || (ta == TOC_ACC_VIEW && !i_prog_disabled));
			assign o_prot_show[2+g] = en && (ta == TOC_ACC_PROT || ta == TOC_ACC_VIEW);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// checks
	a_powerup_clear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_powerup && i_powerup_reset_en |=> o_timer_load && o_timer_load_val == TIMER_RST_VAL)
		else $error("timer not cleared at power-up");
	a_powerup_restore: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_powerup && !i_powerup_reset_en |=> o_timer_load_val == $past(i_saved_timer))
		else $error("saved timer not restored");
	a_track_offset: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_preset_wr2 && !i_preset_wr1 && i_track_en |=> o_preset2 - o_preset1 == $past(offset))
		else $error("tracking offset lost");
	a_track_edit: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_preset_wr1 |=> offset == o_preset2 - o_preset1)
		else $error("preset 1 edit did not set offset");
	a_dur_range: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_dur1 >= DUR_MIN && o_dur1 <= DUR_MAX && o_dur2 >= DUR_MIN && o_dur2 <= DUR_MAX)
		else $error("duration out of range");
	a_out1_on_hit: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		hit[0] && !hit_d[0] && !i_powerup && !i_timer_reset && !i_output_reset |=> act[0])
		else $error("output 1 not activated at preset");
	a_out2_on_hit: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		hit[1] && !hit_d[1] && !i_powerup && !i_timer_reset && !i_output_reset |=> act[1])
		else $error("output 2 not activated at preset");
	a_timed_expire: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		act[0] && i_output_operation_mode[1:0] == TOC_OP_TIMED && tick && dcnt[0] + 1'b1 >= dur[0]
		&& !(hit[0] && !hit_d[0]) && !i_powerup |=> !act[0])
		else $error("timed output 1 not ended");
	a_pu_off: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_powerup && i_output_powerup_state[1:0] == TOC_PU_OFF |=> !act[0])
		else $error("output 1 not off after power-up");
	a_pu_on: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_powerup && i_output_powerup_state[1:0] == TOC_PU_ON |=> act[0])
		else $error("output 1 not on after power-up");
	a_pu_prev: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_powerup && i_output_powerup_state[1:0] == TOC_PU_PREV
		|=> act[0] == ($past(i_output_operation_mode[1:0]) == TOC_OP_LATCHED && $past(i_saved_output[0])))
		else $error("output 1 previous state not restored");
	a_reset_off: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_timer_reset && !i_powerup |=> act == '0)
		else $error("outputs not reset");
	a_out_reset_off: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_output_reset && !i_powerup |=> act == '0)
		else $error("outputs not reset by output reset");
	a_indicator_pol: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_indicator[0] == (act[0] ^ i_output_polarity_invert[0] ^ i_indicator_polarity_invert[0]))
		else $error("indicator polarity wrong");
	a_locked_hidden: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_preset_access_level[1:0] == TOC_ACC_LOCKED |-> !o_main_show[0] && !o_prot_show[0])
		else $error("locked preset visible");
	a_prot_only: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_preset_access_level[1:0] == TOC_ACC_PROT |-> !o_main_show[0] && !o_main_edit[0] && o_prot_show[0])
		else $error("protected preset access wrong");
	a_view_readonly: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_preset_access_level[1:0] == TOC_ACC_VIEW && i_prog_disabled |-> o_main_show[0] && !o_main_edit[0])
		else $error("view-only preset editable at main display");
	a_full_main: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_preset_access_level[1:0] == TOC_ACC_FULL |-> o_main_show[0] && o_main_edit[0] && !o_prot_show[0])
		else $error("full access preset wrong");
	a_time_locked: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_time_access_level[1:0] == TOC_ACC_LOCKED |-> !o_main_show[2] && !o_main_edit[2] && !o_prot_show[2])
		else $error("locked output time visible");
endmodule : toc_timer_output
